// >>> hw/gcer_defines.vh
// constants for the general control and event register bank
// assumes inclusion by bare name from every design file of the block
`ifndef GCER_DEFINES_VH
`define GCER_DEFINES_VH

// ============================================================
// register indices and byte addresses (address = 4 * index)
`define GCER_IDX_CONTROL 8'h86
`define GCER_IDX_STATUS 8'h88
`define GCER_IDX_ENABLE 8'h89
`define GCER_IDX_CLEAR 8'h8a
`define GCER_ADDR_BITS 12
`define GCER_ADDR_CONTROL 12'h218
`define GCER_ADDR_STATUS 12'h220
`define GCER_ADDR_ENABLE 12'h224
`define GCER_ADDR_CLEAR 12'h228

// ============================================================
// general control layout
`define GCER_CTRL_RESET 16'h1000
`define GCER_CTRL_WMASK 16'hff2b
`define GCER_CTRL_PASSTHRU 9
`define GCER_CTRL_LOWSEL 8
`define GCER_CTRL_LOADER_OFF 5
`define GCER_CTRL_SLOT2_OFF 3

// ============================================================
// event status / enable layout
`define GCER_EVT_RESET 8'h00
`define GCER_EVT_MASK 8'hdf
`define GCER_EVT_POWER 7
`define GCER_EVT_HIGH 6
`define GCER_EVT_INPUTS 5
`define GCER_EVT_RSVD 5

// ============================================================
// socket request codes from the socket power logic
`define GCER_REQ_OFF 2'h0
`define GCER_REQ_VCC 2'h1
`define GCER_REQ_PROG 2'h2

// codes sent to the external power switch
`define GCER_SW_GND 2'h0
`define GCER_SW_VCC 2'h1
`define GCER_SW_12V 2'h2
`define GCER_SW_18V 2'h3

// ============================================================
// bus
`define GCER_HTRANS_NONSEQ_BIT 1
`define GCER_ZERO32 32'h00000000

`endif

// >>> hw/gcer_vpp_map.v
// maps one socket's programming-voltage request to a switch code
// assumes request inputs are synchronous levels; output is combinational
`timescale 1ns/1ps
`include "gcer_defines.vh"

module gcer_vpp_map (
  input wire [1:0] vpp_req,
  input wire needs_low,
  input wire high_prog_volt_passthru,
  input wire low_prog_volt_select,
  output reg [1:0] switch_code,
  output wire wants_high
);

  // a card needing low voltage never counts as a genuine high request
  assign wants_high = (vpp_req == `GCER_REQ_PROG) && !needs_low;

  always @* begin
    switch_code = `GCER_SW_GND;
    if (vpp_req == `GCER_REQ_VCC) begin
      switch_code = `GCER_SW_VCC;
    end else if (vpp_req == `GCER_REQ_PROG) begin
      if (needs_low) begin
        // low-voltage request generated from interrogation result
        if (low_prog_volt_select) begin
          switch_code = `GCER_SW_18V;
        end else begin
          switch_code = `GCER_SW_12V;
        end
      end else if (high_prog_volt_passthru) begin
        switch_code = `GCER_SW_12V;
      end else begin
        switch_code = `GCER_SW_GND;
      end
    end
  end

endmodule

// >>> hw/gcer_input_watch.v
// level-change detector for the five general-purpose input terminals
// assumes pin levels are already synchronous to hclk
`timescale 1ns/1ps
`include "gcer_defines.vh"

module gcer_input_watch (
  input wire hclk,
  input wire hresetn,
  input wire [4:0] pin_level,
  input wire [4:0] is_input,
  output wire [4:0] changed
);

  reg [4:0] last_level;
  reg [4:0] primed;

  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_bit
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          last_level[i] <= 1'b0;
          primed[i] <= 1'b0;
        end else begin
          last_level[i] <= pin_level[i];
          // no event until one level has been seen since reset
          primed[i] <= 1'b1;
        end
      end
      assign changed[i] = primed[i] && is_input[i] &&
                          (pin_level[i] != last_level[i]);
    end
  endgenerate

endmodule

// >>> hw/gcer_bank.v
// general control and general-purpose event registers, AHB-Lite slave
// assumes one bus master, single word transfers, inputs sync to hclk
`timescale 1ns/1ps
`include "gcer_defines.vh"

module gcer_bank (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [1:0] vcc_req_a,
  input wire [1:0] vpp_req_a,
  input wire needs_low_a,
  input wire [1:0] vcc_req_b,
  input wire [1:0] vpp_req_b,
  input wire needs_low_b,
  input wire [4:0] general_input,
  input wire [4:0] general_input_mode,
  output reg [1:0] switch_vpp_a,
  output reg [1:0] switch_vpp_b,
  output reg loader_off,
  output reg second_slot_off,
  output reg irq,
  output reg general_event_out_n
);

  // ============================================================
  // registers
  reg [15:0] general_control;
  reg [7:0] event_status;
  reg [7:0] event_enable;

  // ============================================================
  // bus address phase capture
  reg dp_write;
  reg [`GCER_ADDR_BITS-1:0] dp_addr;
  wire ap_valid;
  wire ap_write;
  wire ap_read;
  wire [`GCER_ADDR_BITS-1:0] ap_addr;

  assign ap_valid = hsel && hready && htrans[`GCER_HTRANS_NONSEQ_BIT];
  assign ap_write = ap_valid && hwrite;
  assign ap_read = ap_valid && !hwrite;
  assign ap_addr = haddr[`GCER_ADDR_BITS-1:0];
  // every access completes without wait states and always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= {`GCER_ADDR_BITS{1'b0}};
    end else if (hready) begin
      // address phase only advances while the bus is ready
      dp_write <= ap_write;
      dp_addr <= ap_addr;
    end
  end

  // ============================================================
  // write decode, effective in the data phase
  wire wr_control;
  wire wr_status;
  wire wr_enable;
  wire wr_clear;

  // status and clear writes only touch bits written as one
  assign wr_control = dp_write && (dp_addr == `GCER_ADDR_CONTROL);
  assign wr_status = dp_write && (dp_addr == `GCER_ADDR_STATUS);
  assign wr_enable = dp_write && (dp_addr == `GCER_ADDR_ENABLE);
  assign wr_clear = dp_write && (dp_addr == `GCER_ADDR_CLEAR);

  // ============================================================
  // general control
  reg [15:0] next_general_control;

  always @* begin
    next_general_control = general_control;
    if (wr_control) begin
      // reserved read-only bits never take write data
      next_general_control = hwdata[15:0] & `GCER_CTRL_WMASK;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      general_control <= `GCER_CTRL_RESET;
    end else begin
      general_control <= next_general_control;
    end
  end

  // ============================================================
  // event enable
  reg [7:0] next_event_enable;

  always @* begin
    next_event_enable = event_enable;
    if (wr_enable) begin
      next_event_enable = hwdata[7:0] & `GCER_EVT_MASK;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_enable <= `GCER_EVT_RESET;
    end else begin
      event_enable <= next_event_enable;
    end
  end

  // ============================================================
  // switch request mapping, one mapper per socket
  wire [1:0] next_switch_vpp_a;
  wire [1:0] next_switch_vpp_b;
  wire high_a;
  wire high_b;

  gcer_vpp_map u_map_a (
    .vpp_req(vpp_req_a),
    .needs_low(needs_low_a),
    .high_prog_volt_passthru(general_control[`GCER_CTRL_PASSTHRU]),
    .low_prog_volt_select(general_control[`GCER_CTRL_LOWSEL]),
    .switch_code(next_switch_vpp_a),
    .wants_high(high_a)
  );

  gcer_vpp_map u_map_b (
    .vpp_req(vpp_req_b),
    .needs_low(needs_low_b),
    .high_prog_volt_passthru(general_control[`GCER_CTRL_PASSTHRU]),
    .low_prog_volt_select(general_control[`GCER_CTRL_LOWSEL]),
    .switch_code(next_switch_vpp_b),
    .wants_high(high_b)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_vpp_a <= `GCER_SW_GND;
      switch_vpp_b <= `GCER_SW_GND;
      loader_off <= 1'b0;
      second_slot_off <= 1'b0;
    end else begin
      // registered so the switch never sees a decode glitch
      switch_vpp_a <= next_switch_vpp_a;
      switch_vpp_b <= next_switch_vpp_b;
      // the loader and second function are gated by these levels
      loader_off <= general_control[`GCER_CTRL_LOADER_OFF];
      second_slot_off <= general_control[`GCER_CTRL_SLOT2_OFF];
    end
  end

  // ============================================================
  // event sources
  reg [7:0] last_power;
  reg [1:0] last_high;
  reg src_primed;
  wire [7:0] power_now;
  wire [1:0] high_now;
  wire power_evt;
  wire high_evt;
  wire [4:0] input_evt;
  wire [7:0] set_evt;

  assign power_now = {vcc_req_a, vpp_req_a, vcc_req_b, vpp_req_b};
  assign high_now = {high_a, high_b};

  // the first cycle after reset only samples, so reset is no event
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_primed <= 1'b0;
    end else begin
      src_primed <= 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_power <= 8'h00;
      last_high <= 2'h0;
    end else begin
      last_power <= power_now;
      last_high <= high_now;
    end
  end

  assign power_evt = src_primed && (power_now != last_power);
  assign high_evt = src_primed && (high_now != last_high);

  gcer_input_watch u_watch (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_level(general_input),
    .is_input(general_input_mode),
    .changed(input_evt)
  );

  // bit five is reserved and never set
  assign set_evt = {power_evt, high_evt, 1'b0, input_evt};

  // ============================================================
  // sticky event status
  reg [7:0] clear_bits;
  reg [7:0] next_event_status;

  // status itself and the clear register both clear on a one
  always @* begin
    clear_bits = 8'h00;
    if (wr_status) begin
      clear_bits = hwdata[7:0];
    end else if (wr_clear) begin
      clear_bits = hwdata[7:0];
    end
  end

  // set beats clear in the same cycle, so no event is ever lost
  always @* begin
    next_event_status = event_status & ~clear_bits;
    next_event_status = next_event_status | set_evt;
    next_event_status = next_event_status & `GCER_EVT_MASK;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_status <= `GCER_EVT_RESET;
    end else begin
      event_status <= next_event_status;
    end
  end

  // ============================================================
  // general event output
  wire [7:0] pending;
  wire next_irq;

  assign pending = event_status & event_enable;
  // a flag raised while masked fires as soon as it is unmasked
  assign next_irq = |pending;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
      general_event_out_n <= 1'b1;
    end else begin
      irq <= next_irq;
      general_event_out_n <= !next_irq;
    end
  end

  // ============================================================
  // read data, captured in the address phase
  reg [31:0] next_hrdata;
  wire rd_control;
  wire rd_status;
  wire rd_enable;

  assign rd_control = (ap_addr == `GCER_ADDR_CONTROL);
  assign rd_status = (ap_addr == `GCER_ADDR_STATUS);
  assign rd_enable = (ap_addr == `GCER_ADDR_ENABLE);

  always @* begin
    next_hrdata = `GCER_ZERO32;
    if (rd_control) begin
      next_hrdata = {16'h0000, general_control};
    end else if (rd_status) begin
      next_hrdata = {24'h000000, event_status};
    end else if (rd_enable) begin
      next_hrdata = {24'h000000, event_enable};
    end else begin
      // clear register is write-only; unmapped reads give zero
      next_hrdata = `GCER_ZERO32;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `GCER_ZERO32;
    end else if (ap_read) begin
      // held until the next read, so idle cycles cannot disturb it
      hrdata <= next_hrdata;
    end
  end

endmodule

// >>> bench/gcer_bank_checker.sv
// port assertions for the general control and event register bank
// assumes one hclk domain; bound onto every gcer_bank instance
`timescale 1ns/1ps
`include "gcer_defines.vh"

module gcer_bank_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [1:0] vpp_req_a,
  input wire needs_low_a,
  input wire [1:0] switch_vpp_a,
  input wire loader_off,
  input wire second_slot_off,
  input wire irq,
  input wire general_event_out_n
);
  // ============================================================
  // helpers: last three write address phases
  wire wr_phase = hsel & hready & htrans[1] & hwrite;
  wire rd_phase = hsel & hready & htrans[1] & ~hwrite;
  reg [2:0] wr_hist;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_hist <= 3'h0;
    end else begin
      wr_hist <= {wr_hist[1:0], wr_phase};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ============================================================
  // assertions
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_phase))
    else $error("read data moved without a read");
  chk_event_pol: assert property (general_event_out_n != irq)
    else $error("event output not inverse of irq");
  chk_loader_write: assert property ($changed(loader_off) |-> |wr_hist)
    else $error("loader disable moved without a write");
  chk_slot_write: assert property (
    $changed(second_slot_off) |-> |wr_hist)
    else $error("second slot disable moved without a write");
  chk_irq_drop: assert property ($fell(irq) |-> |wr_hist)
    else $error("irq dropped without a clear or mask write");
  chk_sw_idle: assert property ((vpp_req_a == `GCER_REQ_OFF) |=>
    (switch_vpp_a == `GCER_SW_GND)) else $error("idle request not ground");
  chk_sw_high: assert property (
    (vpp_req_a == `GCER_REQ_PROG && !needs_low_a)
    |=> (switch_vpp_a inside {`GCER_SW_GND, `GCER_SW_12V}))
    else $error("high request mapped wrongly");
  chk_sw_low: assert property (
    (vpp_req_a == `GCER_REQ_PROG && needs_low_a)
    |=> (switch_vpp_a inside {`GCER_SW_12V, `GCER_SW_18V}))
    else $error("low request mapped wrongly");
endmodule

bind gcer_bank gcer_bank_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .vpp_req_a(vpp_req_a), .needs_low_a(needs_low_a),
  .switch_vpp_a(switch_vpp_a), .loader_off(loader_off),
  .second_slot_off(second_slot_off), .irq(irq),
  .general_event_out_n(general_event_out_n));

// >>> bench/gcer_switch_model.sv
// power switch stand-in: turns switch codes into a supply level
// assumes codes straight from the bank; level given in millivolts
`timescale 1ns/1ps
`include "gcer_defines.vh"

module gcer_switch_model #(
  parameter [15:0] vcc_mv = 16'h0ce4
) (
  input wire [1:0] code,
  output reg [15:0] mv
);
  // ============================================================
  // decode; anything unknown leaves the socket grounded
  always @* begin
    case (code)
      `GCER_SW_VCC: mv = vcc_mv;
      `GCER_SW_12V: mv = 16'h2ee0;
      `GCER_SW_18V: mv = 16'h0708;
      default: mv = 16'h0000;
    endcase
  end
endmodule

// >>> bench/tb.sv
// self-checking bench for the general control and event register bank
// assumes bank, checker bind and switch model are compiled before it
`timescale 1ns/1ps
`include "gcer_defines.vh"

module tb;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 32'h0;
  reg [31:0] hwdata = 32'h0;
  reg [1:0] vcc_req_a = 2'h0, vpp_req_a = 2'h0;
  reg [1:0] vcc_req_b = 2'h0, vpp_req_b = 2'h0;
  reg needs_low_a = 1'b0, needs_low_b = 1'b0;
  reg [4:0] general_input = 5'h00;
  reg [4:0] general_input_mode = 5'h15;
  wire hready, hresp, loader_off, second_slot_off, irq, general_event_out_n;
  wire [31:0] hrdata;
  wire [1:0] switch_vpp_a, switch_vpp_b;
  wire [15:0] mv_a;
  reg [1:0] exp_sw;
  reg [31:0] scratch;
  integer i;
  integer error_cnt = 0;
  integer total_checks = 0;

  always #5 hclk = ~hclk;

  gcer_bank DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .vcc_req_a(vcc_req_a), .vpp_req_a(vpp_req_a),
    .needs_low_a(needs_low_a), .vcc_req_b(vcc_req_b),
    .vpp_req_b(vpp_req_b), .needs_low_b(needs_low_b),
    .general_input(general_input), .general_input_mode(general_input_mode),
    .switch_vpp_a(switch_vpp_a), .switch_vpp_b(switch_vpp_b),
    .loader_off(loader_off), .second_slot_off(second_slot_off),
    .irq(irq), .general_event_out_n(general_event_out_n));

  gcer_switch_model u_sw (.code(switch_vpp_a), .mv(mv_a));

  // ============================================================
  // bus and compare tasks
  task chk(input [8*10-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0s exp %h got %h", name, exp, got);
      end
    end
  endtask

  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      scratch = hrdata;
    end
  endtask

  task rdc(input [8*10-1:0] name, input [11:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(name, exp, scratch);
    end
  endtask

  // irq lags the flag or enable write by one edge
  task irqc(input e);
    begin
      repeat (2) @(posedge hclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
      chk("event_n", {31'h0, !e}, {31'h0, general_event_out_n});
    end
  endtask

  task complete_run;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    complete_run;
  end

  // ============================================================
  // tests
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("control", `GCER_ADDR_CONTROL, 32'h1000);
    rdc("status", `GCER_ADDR_STATUS, 32'h0);
    rdc("enable", `GCER_ADDR_ENABLE, 32'h0);
    rdc("unmapped", 12'h000, 32'h0);
    chk("off_bits", 32'h0, {30'h0, loader_off, second_slot_off});
    bus(1'b1, `GCER_ADDR_CONTROL, 32'h10fc);
    rdc("control", `GCER_ADDR_CONTROL, 32'h1028);
    chk("off_bits", 32'h3, {30'h0, loader_off, second_slot_off});
    // every passthru / low select / card type combination
    for (i = 0; i < 8; i = i + 1) begin
      bus(1'b1, `GCER_ADDR_CONTROL, {22'h4, i[2:1], 8'h0});
      needs_low_a <= i[0];
      needs_low_b <= i[0];
      vpp_req_a <= `GCER_REQ_PROG;
      vpp_req_b <= `GCER_REQ_PROG;
      repeat (3) @(posedge hclk);
      exp_sw = i[0] ? (i[1] ? 2'h3 : 2'h2) : (i[2] ? 2'h2 : 2'h0);
      chk("switch_a", {30'h0, exp_sw}, {30'h0, switch_vpp_a});
      chk("switch_b", {30'h0, exp_sw}, {30'h0, switch_vpp_b});
      chk("volts_a", exp_sw == 2'h3 ? 32'h708 : exp_sw == 2'h2 ? 32'h2ee0
        : 32'h0, {16'h0, mv_a});
    end
    chk("off_bits", 32'h0, {30'h0, loader_off, second_slot_off});
    vpp_req_a <= `GCER_REQ_VCC;
    vpp_req_b <= `GCER_REQ_VCC;
    repeat (3) @(posedge hclk);
    chk("switch_a", 32'h1, {30'h0, switch_vpp_a});
    chk("switch_b", 32'h1, {30'h0, switch_vpp_b});
    chk("volts_a", 32'hce4, {16'h0, mv_a});
    vpp_req_a <= `GCER_REQ_OFF;
    vpp_req_b <= `GCER_REQ_OFF;
    needs_low_a <= 1'b0;
    needs_low_b <= 1'b0;
    repeat (3) @(posedge hclk);
    bus(1'b1, `GCER_ADDR_STATUS, 32'hff);
    rdc("status", `GCER_ADDR_STATUS, 32'h0);
    vcc_req_b <= `GCER_REQ_VCC;
    repeat (3) @(posedge hclk);
    rdc("status", `GCER_ADDR_STATUS, 32'h80);
    vpp_req_a <= `GCER_REQ_PROG;
    repeat (3) @(posedge hclk);
    rdc("status", `GCER_ADDR_STATUS, 32'hc0);
    general_input <= 5'h1f;
    repeat (3) @(posedge hclk);
    rdc("status", `GCER_ADDR_STATUS, 32'hd5);
    irqc(1'b0);
    bus(1'b1, `GCER_ADDR_ENABLE, 32'hff);
    rdc("enable", `GCER_ADDR_ENABLE, 32'hdf);
    irqc(1'b1);
    bus(1'b1, `GCER_ADDR_STATUS, 32'h80);
    rdc("status", `GCER_ADDR_STATUS, 32'h55);
    bus(1'b1, `GCER_ADDR_STATUS, 32'h0);
    rdc("status", `GCER_ADDR_STATUS, 32'h55);
    bus(1'b1, `GCER_ADDR_ENABLE, 32'h20);
    irqc(1'b0);
    bus(1'b1, `GCER_ADDR_ENABLE, 32'h01);
    irqc(1'b1);
    bus(1'b1, `GCER_ADDR_CLEAR, 32'h15);
    rdc("status", `GCER_ADDR_STATUS, 32'h40);
    rdc("clear", `GCER_ADDR_CLEAR, 32'h0);
    irqc(1'b0);
    complete_run;
  end
endmodule
